// ==== core/local_bus_ctrl.sv ====
`timescale 1ns/1ns
// Local bus control: strobes, ready, transceiver enable, lock, hold, selects.
module local_bus_ctrl
    import local_bus_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Core side request.
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_mem,
    input wire logic req_locked,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic instr_boundary,
    input wire logic [1:0] queue_event,
    output logic req_done,
    output logic [15:0] rd_data_q,
    // Chip-select programming from the core.
    input wire logic sel_wr,
    input wire logic [19:0] upper_base,
    input wire logic [19:0] upper_top,
    input wire logic [19:0] lower_base,
    input wire logic [19:0] lower_top,
    input wire logic upper_no_ready,
    input wire logic lower_no_ready,
    // Pins.
    input wire logic async_ready_in,
    input wire logic async_ready_fall,
    input wire logic sync_ready_in,
    input wire logic hold_req,
    input wire logic read_strobe_in,
    input wire logic lock_in,
    input wire logic upper_select_in,
    input wire logic lower_select_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic [19:0] addr_out,
    output logic ctrl_oe,
    output logic read_n,
    output logic write_n,
    output logic addr_latch,
    output logic transceiver_enable_n,
    output logic lock_n,
    output logic lock_oe,
    output logic hold_acknowledge,
    output logic upper_select_n,
    output logic lower_select_n,
    output logic emulation_isolation_mode,
    output logic queue_report_select
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    select_if sel ();
    phase_t phase_q; // Bus cycle phase.
    logic write_q; // Cycle is a write.
    logic locked_q; // Cycle runs under lock.
    logic async_ready_in_s1_q; // First async ready stage.
    logic async_ready_in_s2_q; // Second async ready stage.
    logic [19:0] ub_q; // Upper window base.
    logic [19:0] ut_q; // Upper window top.
    logic [19:0] lb_q; // Lower window base.
    logic [19:0] lt_q; // Lower window top.
    logic unr_q; // Upper range ignores ready.
    logic lnr_q; // Lower range ignores ready.
    logic qmode_q; // Queue report mode latched at reset.
    logic cycle_end; // Current data phase may finish.
    logic finish; // Ready seen and the strobe has already been on the pins.
    logic up_prog_q; // Upper window reprogrammed since reset.
    logic grant; // Bus may be handed over now.

    assign sel.addr = addr_out;
    assign sel.is_mem = req_mem;

    select_decode u_dec (
        .sel(sel.dec),
        .upper_base(ub_q),
        .upper_top(ut_q),
        .lower_base(lb_q),
        .lower_top(lt_q),
        .upper_no_ready(unr_q),
        .lower_no_ready(lnr_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Ready handling and hold grant.
    // Async ready on the rising edge goes through two flops; the falling-edge
    // sample arrives already synchronous. Sync ready is used directly.
    always_comb begin
        cycle_end = async_ready_in_s2_q || async_ready_fall
            || sync_ready_in
            || sel.skip_ready;
        // A cycle only ends after its strobe has been driven for a clock, so
        // even an ignore-ready range moves its data under an active strobe.
        finish = cycle_end && !transceiver_enable_n;
        grant = hold_req && instr_boundary && !req_locked && !locked_q;
    end

    // Two-flop synchroniser for the asynchronous ready.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            async_ready_in_s1_q <= 1'b0;
            async_ready_in_s2_q <= 1'b0;
        end else if (clk_en) begin
            async_ready_in_s1_q <= async_ready_in;
            async_ready_in_s2_q <= async_ready_in_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset-time straps.
    // During reset the read and select pins are inputs; capture them.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            qmode_q <= !read_strobe_in;
            emulation_isolation_mode <= !upper_select_in && !lower_select_in;
        end
    end
    assign queue_report_select = qmode_q;

    ////////////////////////////////////////////////////////////////////////
    // Chip-select windows, reset to defaults and reprogrammed by the core.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ub_q <= UPPER_BASE_RST;
            ut_q <= UPPER_TOP_RST;
            lb_q <= LOWER_BASE_RST;
            lt_q <= LOWER_TOP_RST;
            unr_q <= 1'b0;
            lnr_q <= 1'b0;
            up_prog_q <= 1'b0;
        end else if (clk_en && sel_wr) begin
            up_prog_q <= 1'b1;
            ub_q <= upper_base;
            ut_q <= upper_top;
            lb_q <= lower_base;
            lt_q <= lower_top;
            unr_q <= upper_no_ready;
            lnr_q <= lower_no_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phase_q <= PH_IDLE;
            write_q <= 1'b0;
            locked_q <= 1'b0;
            addr_out <= '0;
            data_out <= '0;
            rd_data_q <= '0;
            req_done <= 1'b0;
        end else if (clk_en) begin
            req_done <= 1'b0;
            case (phase_q)
                // Hold is checked first at a boundary, else start a cycle.
                PH_IDLE: begin
                    if (grant) begin
                        phase_q <= PH_HOLD;
                    end else if (req_valid) begin
                        phase_q <= PH_ADDR;
                        write_q <= req_write;
                        locked_q <= req_locked;
                        addr_out <= req_addr;
                        data_out <= req_wdata;
                    end
                end
                // Address phase lasts one clock.
                PH_ADDR: begin
                    phase_q <= PH_DATA;
                end
                // Wait states until ready or an ignore-ready range.
                PH_DATA: begin
                    if (finish) begin
                        phase_q <= PH_DONE;
                        rd_data_q <= data_in;
                    end
                end
                // Finish and report to the core.
                PH_DONE: begin
                    phase_q <= PH_IDLE;
                    req_done <= 1'b1;
                    locked_q <= req_locked && locked_q;
                end
                // Stay floated while the other master keeps requesting.
                PH_HOLD: begin
                    if (!hold_req) begin
                        phase_q <= PH_IDLE;
                    end
                end
                default: begin
                    phase_q <= PH_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, all registered from the current phase except the queue report codes.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            read_n <= 1'b1;
            write_n <= 1'b1;
            addr_latch <= 1'b0;
            transceiver_enable_n <= 1'b1;
            data_oe <= 1'b0;
            ctrl_oe <= 1'b0;
            lock_n <= 1'b1;
            lock_oe <= 1'b0;
            hold_acknowledge <= 1'b0;
            upper_select_n <= 1'b1;
            lower_select_n <= 1'b1;
        end else if (clk_en) begin
            hold_acknowledge <= (phase_q == PH_HOLD) && hold_req;
            ctrl_oe <= (phase_q != PH_HOLD);
            lock_oe <= (phase_q != PH_HOLD);
            lock_n <= !(locked_q && (phase_q == PH_ADDR || phase_q == PH_DATA));
            transceiver_enable_n <= !(phase_q == PH_DATA && !finish);
            data_oe <= (phase_q == PH_DATA) && write_q && !finish;
            read_n <= !(phase_q == PH_DATA && !write_q && !finish);
            // The reset window serves memory only until software reprograms it.
            upper_select_n <= !((phase_q == PH_ADDR || phase_q == PH_DATA)
                && sel.upper_hit && (req_mem || up_prog_q));
            lower_select_n <= !((phase_q == PH_ADDR || phase_q == PH_DATA)
                && sel.lower_hit);
            if (qmode_q) begin
                // Queue report replaces write strobe and latch pulse.
                {write_n, addr_latch} <= queue_event;
            end else begin
                write_n <= !(phase_q == PH_DATA && write_q && !finish);
                addr_latch <= (phase_q == PH_IDLE) && req_valid && !grant;
            end
        end
    end
endmodule : local_bus_ctrl

// ==== core/local_bus_pkg.sv ====
package local_bus_pkg;
    // Width of the physical address.
    localparam int ADDR_W = 20;
    // Reset window of the upper chip select.
    localparam logic [19:0] UPPER_BASE_RST = 20'hFFC00;
    localparam logic [19:0] UPPER_TOP_RST = 20'hFFFFF;
    // Lower select range after reset: empty, so it never matches.
    localparam logic [19:0] LOWER_BASE_RST = 20'hFFFFF;
    localparam logic [19:0] LOWER_TOP_RST = 20'h00000;
    // Queue status codes as {hi, lo}.
    localparam logic [1:0] QS_NONE = 2'h0;
    localparam logic [1:0] QS_FIRST = 2'h1;
    localparam logic [1:0] QS_NEXT = 2'h3;
    localparam logic [1:0] QS_EMPTY = 2'h2;
    // Bus cycle phases.
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DATA,
        PH_DONE,
        PH_HOLD
    } phase_t;
endpackage : local_bus_pkg

// ==== core/select_decode.sv ====
`timescale 1ns/1ns
// Range decoder for the upper and lower chip selects.
module select_decode
    import local_bus_pkg::*;
(
    select_if.dec sel,
    input wire logic [19:0] upper_base,
    input wire logic [19:0] upper_top,
    input wire logic [19:0] lower_base,
    input wire logic [19:0] lower_top,
    input wire logic upper_no_ready,
    input wire logic lower_no_ready
);
    // Inclusive window compare, used for both selects.
    function automatic logic in_win(input logic [19:0] a, input logic [19:0] lo,
        input logic [19:0] hi);
        in_win = (a >= lo) && (a <= hi);
    endfunction : in_win

    // Upper select covers memory and I/O; lower select memory only.
    always_comb begin
        sel.upper_hit = in_win(sel.addr, upper_base, upper_top);
        sel.lower_hit = sel.is_mem && in_win(sel.addr, lower_base, lower_top);
        sel.skip_ready = (sel.upper_hit && upper_no_ready)
            || (sel.lower_hit && lower_no_ready);
    end
endmodule : select_decode

// ==== core/select_if.sv ====
`timescale 1ns/1ns
// Carries a bus request and the chip-select decode back to the sequencer.
interface select_if;
    logic [19:0] addr; // Address of the cycle.
    logic is_mem; // High for memory, low for I/O.
    logic upper_hit; // Upper window matches.
    logic lower_hit; // Lower window matches.
    logic skip_ready; // Range ignores external ready.
    modport seq (output addr, output is_mem, input upper_hit, input lower_hit,
        input skip_ready);
    modport dec (input addr, input is_mem, output upper_hit, output lower_hit,
        output skip_ready);
endinterface : select_if

// ==== testbench/bus_partner.sv ====
`timescale 1ns/1ns
// Memory and I/O device on the far side of the bus.
module bus_partner (
    input wire logic ref_clk,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [19:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic [1:0] waits,
    input wire logic use_async,
    input wire logic mute,
    output logic [15:0] data_in,
    output logic sync_ready_in,
    output logic async_ready_in
);
    logic [15:0] mem [16]; // Storage, indexed by the low address bits.
    logic [2:0] cnt_q; // Wait states spent in this strobe.
    logic rdy_q; // Ready, raised after the wait count.
    // Counts waits while a strobe is low, then holds ready until the strobe ends.
    always @(posedge ref_clk) begin
        cnt_q <= (read_n && write_n) ? 3'h0 : cnt_q + 3'h1;
        rdy_q <= !(read_n && write_n) && cnt_q >= {1'b0, waits} && !mute;
        if (!write_n && rdy_q) mem[addr_out[3:0]] <= data_out;
    end
    // A released data bus shows a pattern that changes every half cycle.
    assign data_in = read_n ? {16{ref_clk}} ^ 16'h5A5A : mem[addr_out[3:0]];
    assign sync_ready_in = rdy_q && !use_async;
    assign async_ready_in = rdy_q && use_async;
endmodule : bus_partner

// ==== testbench/local_bus_ctrl_props.sv ====
`timescale 1ns/1ns
// Pin-level checks of the bus controller.
module local_bus_ctrl_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic req_mem,
    input wire logic [19:0] req_addr,
    input wire logic sel_wr,
    input wire logic upper_no_ready,
    input wire logic lower_no_ready,
    input wire logic async_ready_in,
    input wire logic async_ready_fall,
    input wire logic sync_ready_in,
    input wire logic hold_req,
    input wire logic req_done,
    input wire logic ctrl_oe,
    input wire logic data_oe,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic transceiver_enable_n,
    input wire logic lock_n,
    input wire logic hold_acknowledge,
    input wire logic upper_select_n,
    input wire logic lower_select_n,
    input wire logic queue_report_select
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic prog_q; // Windows have been loaded since reset.
    logic [3:0] idle_q; // Cycles with every ready input low.
    // Tracks programming and how long no ready has been offered.
    always_ff @(posedge ref_clk) begin
        prog_q <= rst_n && (prog_q || sel_wr);
        idle_q <= (sync_ready_in || async_ready_in || async_ready_fall) ? 4'h0 :
            idle_q + {3'h0, idle_q != 4'hF};
    end
    sequence s_floated;
        !ctrl_oe && !data_oe;
    endsequence
    a_lock_blocks_hold: assert property (!lock_n |-> !hold_acknowledge)
        else $error("hold granted during lock");
    a_hold_floats_bus: assert property (hold_acknowledge |-> s_floated)
        else $error("bus driven while granted");
    a_hold_release: assert property ($fell(hold_req) && hold_acknowledge |-> ##[1:2] !hold_acknowledge)
        else $error("grant kept after request dropped");
    a_den_data_only: assert property (!transceiver_enable_n && !queue_report_select |->
        !read_n || !write_n)
        else $error("transceiver enabled outside transfer");
    a_lower_mem_only: assert property (!lower_select_n |-> req_mem)
        else $error("lower select on I/O cycle");
    a_upper_reset_win: assert property (!prog_q && !upper_select_n |->
        req_mem && req_addr >= 20'hFFC00)
        else $error("upper select outside reset window");
    a_lower_reset_off: assert property (!prog_q |-> lower_select_n)
        else $error("lower select before programming");
    a_wait_for_ready: assert property (idle_q >= 4'h6 && !upper_no_ready && !lower_no_ready
        |-> !req_done)
        else $error("cycle ended without ready");
endmodule : local_bus_ctrl_props

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
// Self-checking bench for the local bus controller.
module tb;
    import local_bus_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic req_mem = 1'b1, req_locked = 1'b0, instr_boundary = 1'b0, sel_wr = 1'b0;
    logic upper_no_ready = 1'b0, lower_no_ready = 1'b0, async_ready_fall = 1'b0;
    logic hold_req = 1'b0, read_strobe_in = 1'b1, lock_in = 1'b1;
    logic upper_select_in = 1'b1, lower_select_in = 1'b1, use_async = 1'b0;
    logic mute = 1'b0, deaf = 1'b0, up_seen = 1'b0, lo_seen = 1'b0;
    logic [1:0] queue_event = 2'h0, waits = 2'h0;
    logic [19:0] req_addr = 20'h0, upper_base = 20'h00100, upper_top = 20'h001FF;
    logic [19:0] lower_base = 20'h00000, lower_top = 20'h000FF, addr_out;
    logic [15:0] req_wdata = 16'h0, data_in, data_out, rd_data_q, shadow [16], exp_q [$];
    logic req_done, data_oe, ctrl_oe, read_n, write_n, addr_latch, transceiver_enable_n;
    logic lock_n, lock_oe, hold_acknowledge, upper_select_n, lower_select_n;
    logic emulation_isolation_mode, queue_report_select, async_ready_in, sync_ready_in;
    int n_mismatch = 0, checks_done = 0, seed = 32'hd4489cde;
    always #5 ref_clk = ~ref_clk;
    local_bus_ctrl local_bus_ctrl_inst (.*);
    bus_partner bus_partner_inst (.ref_clk(ref_clk), .read_n(read_n), .write_n(write_n),
        .addr_out(addr_out), .data_out(data_out), .waits(waits), .use_async(use_async),
        .mute(mute || deaf), .data_in(data_in), .sync_ready_in(sync_ready_in),
        .async_ready_in(async_ready_in));
    // Collects which selects went low during the current request.
    always @(posedge ref_clk) begin
        up_seen <= req_valid && (up_seen || !upper_select_n);
        lo_seen <= req_valid && (lo_seen || !lower_select_n);
        if (req_done === 1'b1 && !req_write && exp_q.size() > 0) cmp(rd_data_q, exp_q.pop_front());
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // Waits a bounded time for done (w=0) or the hold grant (w=1) to reach lvl.
    task automatic wait_for(input bit w, input logic lvl);
        for (int k = 0; k < 200; k++) begin
            @(negedge ref_clk);
            if ((w ? hold_acknowledge : req_done) === lvl) return;
        end
        n_mismatch++;
        print_verdict();
    endtask : wait_for
    // One bus cycle; st cycles of partner silence must not end it.
    task automatic bus_op(input logic [19:0] a, input logic m, w, input int st);
        @(negedge ref_clk);
        req_addr = a;
        req_mem = m;
        req_write = w;
        req_wdata = 16'($random(seed));
        waits = 2'($random(seed));
        use_async = 1'($random(seed));
        if (!w) exp_q.push_back(shadow[a[3:0]]);
        if (w) shadow[a[3:0]] = req_wdata;
        mute = (st != 0);
        req_valid = 1'b1;
        repeat (st) begin
            @(posedge ref_clk);
            cmp({15'h0, req_done}, 16'h0);
        end
        @(negedge ref_clk);
        mute = 1'b0;
        wait_for(0, 1'b1);
        // Drop the request while done stands, before the idle edge retakes it.
        req_valid = 1'b0;
    endtask : bus_op
    // Write then read back one place and compare which selects fired.
    task automatic pair(input logic [19:0] a, input logic m, eu, el);
        bus_op(a, m, 1'b1, 0);
        bus_op(a, m, 1'b0, 0);
        cmp({14'h0, up_seen, lo_seen}, {14'h0, eu, el});
    endtask : pair
    // Resets with the strobe and select pins held at rs, then checks mode capture.
    task automatic do_reset(input logic rs);
        @(negedge ref_clk);
        rst_n = 1'b0;
        read_strobe_in = rs;
        upper_select_in = rs;
        lower_select_in = rs;
        repeat (6) @(negedge ref_clk);
        cmp({15'h0, lock_oe}, 16'h0);
        rst_n = 1'b1;
        read_strobe_in = 1'b1;
        repeat (2) @(negedge ref_clk);
        cmp({15'h0, queue_report_select}, {15'h0, !rs});
        cmp({15'h0, emulation_isolation_mode}, {15'h0, !rs});
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        do_reset(1'b1);
        pair(20'hFFC02, 1'b1, 1'b1, 1'b0);
        pair(20'h00016, 1'b1, 1'b0, 1'b0);
        @(negedge ref_clk);
        sel_wr = 1'b1;
        @(negedge ref_clk);
        sel_wr = 1'b0;
        pair(20'h00016, 1'b1, 1'b0, 1'b1);
        pair(20'h00015, 1'b0, 1'b0, 1'b0);
        pair(20'h00124, 1'b0, 1'b1, 1'b0);
        bus_op(20'h00124, 1'b0, 1'b0, 30);
        // A locked cycle and a non-boundary cycle must not hand over the bus.
        hold_req = 1'b1;
        instr_boundary = 1'b1;
        req_locked = 1'b1;
        bus_op(20'h00016, 1'b1, 1'b0, 0);
        repeat (10) @(negedge ref_clk);
        cmp({15'h0, hold_acknowledge}, 16'h0);
        instr_boundary = 1'b0;
        req_locked = 1'b0;
        bus_op(20'h00015, 1'b0, 1'b0, 0);
        repeat (10) @(negedge ref_clk);
        cmp({15'h0, hold_acknowledge}, 16'h0);
        instr_boundary = 1'b1;
        wait_for(1, 1'b1);
        cmp({14'h0, ctrl_oe, data_oe}, 16'h0);
        @(negedge ref_clk);
        hold_req = 1'b0;
        wait_for(1, 1'b0);
        repeat (2) @(posedge ref_clk);
        cmp({15'h0, ctrl_oe}, 16'h1);
        // A range that ignores ready ends its cycle with the partner silent.
        @(negedge ref_clk);
        lower_no_ready = 1'b1;
        sel_wr = 1'b1;
        @(negedge ref_clk);
        sel_wr = 1'b0;
        deaf = 1'b1;
        bus_op(20'h00016, 1'b1, 1'b0, 0);
        deaf = 1'b0;
        // Queue report mode: write strobe and latch pins carry every code.
        do_reset(1'b0);
        for (int c = 0; c < 4; c++) begin
            @(negedge ref_clk);
            queue_event = 2'(c);
            repeat (3) @(posedge ref_clk);
            cmp({14'h0, write_n, addr_latch}, 16'(c));
        end
        print_verdict();
    end
endmodule : tb
bind local_bus_ctrl local_bus_ctrl_props local_bus_ctrl_props_inst (.*);
